// >>> rtl/rrunit_top.sv
// Return and software reset instruction unit with a Wishbone slave.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "rrunit_cfg.svh"

module rrunit_top
   import rrunit_pkg::*;
#(
   parameter int PC_W        = 21,
   parameter int STACK_DEPTH = 31,
   parameter int SP_W        = 5
) (
   input  wire logic              sys_clk,      // Core clock, 100 MHz.
   input  wire logic              rstn,         // Async reset, active low.
   input  wire logic [7:0]        wb_adr_i,     // Wishbone byte address.
   input  wire logic [31:0]       wb_dat_i,     // Wishbone write data.
   output logic      [31:0]       wb_dat_o,     // Wishbone read data.
   input  wire logic [3:0]        wb_sel_i,     // Wishbone byte enables.
   input  wire logic              wb_we_i,      // Wishbone write.
   input  wire logic              wb_cyc_i,     // Wishbone cycle.
   input  wire logic              wb_stb_i,     // Wishbone strobe.
   output logic                   wb_ack_o,     // Wishbone acknowledge.
   input  wire logic [15:0]       instr_word,   // Fetched opcode.
   input  wire logic              instr_valid,  // Opcode offered.
   output logic                   instr_ready,  // Opcode taken in Q1.
   input  wire logic              push_valid,   // Call logic push request.
   input  wire logic [PC_W-1:0]   push_addr,    // Return address to push.
   output logic                   push_ready,   // Push may be taken.
   output logic      [PC_W-1:0]   pc_value,     // Program counter.
   output logic                   pc_load,      // PC reloaded this clock.
   output rrunit_ctx_t            core_ctx,     // Live work, flags, bank.
   output logic      [7:0]        pc_high_latch,  // High PC latch.
   output logic      [4:0]        pc_upper_latch, // Upper PC latch.
   output logic                   global_irq_enable_high, // High enable.
   output logic                   global_irq_enable_low,  // Low enable.
   output logic                   soft_reset,   // Software reset pulse.
   output rrunit_phase_t          quarter_phase // Current quarter.
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Merge a bus write into an old word under the byte enables.
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Decode one opcode into the operation it asks for.
   function automatic rrunit_op_t decode_op(input logic [15:0] word);
      rrunit_op_t r;
      r = RR_OP_NONE;
      if (word == `RR_OP_SOFT_RESET) begin
         r = RR_OP_SRST;
      end else if ((word & `RR_OP_SEL_MASK) == `RR_OP_IRET) begin
         r = RR_OP_IRET;
      end else if ((word & `RR_OP_SEL_MASK) == `RR_OP_RET) begin
         r = RR_OP_RET;
      end else if (word[15:8] == `RR_OP_LIT_PREFIX) begin
         r = RR_OP_LIT;
      end
      return r;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   rrunit_phase_t     next_phase;
   rrunit_op_t        op, next_op, last_op, next_last_op;
   logic [7:0]        operand, next_operand, next_lath;
   logic [4:0]        next_latu;
   logic              idle_cycle, next_idle_cycle, pop_now, push_take;
   logic              leave_high, next_leave_high, next_gieh, next_giel;
   logic              underflow, next_underflow, overflow, next_overflow;
   logic              next_pc_load, next_soft_reset, next_ack, bus_write;
   logic [SP_W-1:0]   sp, next_sp, top_addr;
   logic [PC_W-1:0]   next_pc_value, stack_top_entry;
   rrunit_ctx_t       next_core_ctx, shadow, next_shadow;
   logic [31:0]       next_dat, wv, rd_word;

   // ****************************************************************
   // Return stack
   // ****************************************************************
   // A pop is due in Q4 of a return's first cycle.
   assign pop_now = (quarter_phase == RR_Q4) && !idle_cycle &&
                    (op == RR_OP_IRET || op == RR_OP_RET || op == RR_OP_LIT);
   // Pushes are held off while a pop lands, so the pointer moves once.
   assign push_ready = !pop_now;
   assign push_take  = push_valid && push_ready &&
                       (sp < SP_W'(STACK_DEPTH));
   // The top entry sits one below the pointer; read data lags one clock,
   // which is long settled by the next Q4.
   assign top_addr   = (sp == '0) ? '0 : sp - SP_W'(1);

   rrunit_stack_mem #(
      .WIDTH (PC_W),
      .DEPTH (STACK_DEPTH),
      .AW    (SP_W)
   ) u_stack (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .wr_en   (push_take),
      .wr_addr (sp),
      .wr_data (push_addr),
      .rd_addr (top_addr),
      .rd_data (stack_top_entry)
   );

   // Opcodes are only taken in Q1 outside the idle second cycle.
   assign instr_ready = (quarter_phase == RR_Q1) && !idle_cycle;
   assign bus_write   = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;

   // ****************************************************************
   // Register read multiplexer
   // ****************************************************************

   // Unmapped addresses read as zero and are still acknowledged.
   always_comb begin
      rd_word = 32'h0000_0000;
      case (wb_adr_i)
         `RR_OFF_CTRL: begin
            rd_word[`RR_CTRL_GIEH]     = global_irq_enable_high;
            rd_word[`RR_CTRL_GIEL]     = global_irq_enable_low;
            rd_word[`RR_CTRL_LEAVE_HI] = leave_high;
            rd_word[`RR_CTRL_UNDER]    = underflow;
            rd_word[`RR_CTRL_OVER]     = overflow;
         end
         `RR_OFF_WORK:   rd_word[7:0] = core_ctx.work;
         `RR_OFF_FLAGS:  rd_word[7:0] = core_ctx.flags;
         `RR_OFF_BANK:   rd_word[3:0] = core_ctx.bank_select;
         `RR_OFF_SHADOW: begin
            rd_word[7:0] = shadow.work;
            rd_word[`RR_SHD_FLAGS_LSB +: 8] = shadow.flags;
            rd_word[`RR_SHD_BANK_LSB +: 4]  = shadow.bank_select;
         end
         `RR_OFF_LATCH: begin
            rd_word[7:0] = pc_high_latch;
            rd_word[`RR_LAT_UPPER_LSB +: 5] = pc_upper_latch;
         end
         `RR_OFF_PC:     rd_word[PC_W-1:0] = pc_value;
         `RR_OFF_SP:     rd_word[SP_W-1:0] = sp;
         `RR_OFF_TOS:    rd_word[PC_W-1:0] = stack_top_entry;
         `RR_OFF_LASTOP: rd_word[4:0] = last_op;
         default:        rd_word = 32'h0000_0000;
      endcase
   end

   // ****************************************************************
   // Next state of the whole unit
   // ****************************************************************

   // Order of precedence: bus writes, then instruction effects, then
   // hardware flag sets, and a software reset over everything.
   always_comb begin
      next_phase      = quarter_phase;
      next_op         = op;
      next_last_op    = last_op;
      next_operand    = operand;
      next_idle_cycle = idle_cycle;
      next_sp         = sp;
      next_pc_value   = pc_value;
      next_pc_load    = 1'b0;
      next_core_ctx   = core_ctx;
      next_shadow     = shadow;
      next_lath       = pc_high_latch;
      next_latu       = pc_upper_latch;
      next_gieh       = global_irq_enable_high;
      next_giel       = global_irq_enable_low;
      next_leave_high = leave_high;
      next_underflow  = underflow;
      next_overflow   = overflow;
      next_soft_reset = 1'b0;
      wv              = 32'h0000_0000;

      // Classic slave: ack one clock after the strobe, dropped next clock.
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_dat = next_ack ? rd_word : wb_dat_o;

      // A write lands at the edge where the master sees ack.
      if (bus_write) begin
         wv = merge_sel(rd_word, wb_dat_i, wb_sel_i);
         case (wb_adr_i)
            `RR_OFF_CTRL: begin
               next_gieh       = wv[`RR_CTRL_GIEH];
               next_giel       = wv[`RR_CTRL_GIEL];
               next_leave_high = wv[`RR_CTRL_LEAVE_HI];
               // Sticky flags clear on writing one.
               next_underflow = underflow &
                                ~(wb_sel_i[0] & wb_dat_i[`RR_CTRL_UNDER]);
               next_overflow  = overflow &
                                ~(wb_sel_i[0] & wb_dat_i[`RR_CTRL_OVER]);
            end
            `RR_OFF_WORK:  next_core_ctx.work        = wv[7:0];
            `RR_OFF_FLAGS: next_core_ctx.flags       = wv[7:0];
            `RR_OFF_BANK:  next_core_ctx.bank_select = wv[3:0];
            `RR_OFF_SHADOW: begin
               next_shadow.work        = wv[7:0];
               next_shadow.flags       = wv[`RR_SHD_FLAGS_LSB +: 8];
               next_shadow.bank_select = wv[`RR_SHD_BANK_LSB +: 4];
            end
            `RR_OFF_LATCH: begin
               next_lath = wv[7:0];
               next_latu = wv[`RR_LAT_UPPER_LSB +: 5];
            end
            default: ;
         endcase
      end

      // Quarter phases run free: Q1, Q2, Q3, Q4 and round again.
      case (quarter_phase)
         RR_Q1:   next_phase = RR_Q2;
         RR_Q2:   next_phase = RR_Q3;
         RR_Q3:   next_phase = RR_Q4;
         RR_Q4:   next_phase = RR_Q1;
         default: next_phase = RR_Q1;
      endcase

      if (instr_ready) begin
         next_op      = instr_valid ? decode_op(instr_word) : RR_OP_NONE;
         next_operand = instr_word[7:0];
      end

      // A push from the call logic moves the pointer up.
      if (push_take) begin
         next_sp = sp + SP_W'(1);
      end else if (push_valid && push_ready) begin
         next_overflow = 1'b1;
      end

      if (quarter_phase == RR_Q4) begin
         next_idle_cycle = 1'b0;
         next_op         = RR_OP_NONE;
         if (!idle_cycle && op != RR_OP_NONE) begin
            next_last_op = op;
         end
         if (pop_now) begin
            next_idle_cycle = 1'b1;
            next_pc_value = stack_top_entry;
            next_pc_load  = 1'b1;
            if (sp != '0) begin
               next_sp = sp - SP_W'(1);
            end else begin
               next_underflow = 1'b1;
            end
            next_lath = pc_high_latch;
            next_latu = pc_upper_latch;
         end
         if (pop_now && op == RR_OP_IRET) begin
            if (leave_high) begin
               next_gieh = 1'b1;
            end else begin
               next_giel = 1'b1;
            end
         end
         // shadow restore when s is set.
         if (pop_now && operand[0] &&
             (op == RR_OP_IRET || op == RR_OP_RET)) begin
            next_core_ctx = shadow;
         end
         if (pop_now && op == RR_OP_LIT) begin
            next_core_ctx.work = operand;
         end
         // software reset, one cycle.
         // Phase, op, idle and last op already take their Q4 values above.
         if (!idle_cycle && op == RR_OP_SRST) begin
            next_soft_reset = 1'b1;
            next_sp         = '0;
            next_pc_value   = '0;
            next_pc_load    = 1'b1;
            next_core_ctx   = '{`RR_RST_WORK, `RR_RST_FLAGS, `RR_RST_BANK};
            next_shadow     = '{`RR_RST_WORK, `RR_RST_FLAGS, `RR_RST_BANK};
            next_lath       = `RR_RST_LATH;
            next_latu       = `RR_RST_LATU;
            next_gieh       = 1'b0;
            next_giel       = 1'b0;
            next_leave_high = 1'b0;
            next_underflow  = 1'b0;
            next_overflow   = 1'b0;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Master clear values match what the software reset loads above.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         quarter_phase          <= RR_Q1;
         op                     <= RR_OP_NONE;
         last_op                <= RR_OP_NONE;
         operand                <= 8'h00;
         idle_cycle             <= 1'b0;
         sp                     <= '0;
         pc_value               <= '0;
         pc_load                <= 1'b0;
         core_ctx <= '{`RR_RST_WORK, `RR_RST_FLAGS, `RR_RST_BANK};
         shadow   <= '{`RR_RST_WORK, `RR_RST_FLAGS, `RR_RST_BANK};
         pc_high_latch          <= `RR_RST_LATH;
         pc_upper_latch         <= `RR_RST_LATU;
         global_irq_enable_high <= 1'b0;
         global_irq_enable_low  <= 1'b0;
         leave_high             <= 1'b0;
         underflow              <= 1'b0;
         overflow               <= 1'b0;
         soft_reset             <= 1'b0;
         wb_ack_o               <= 1'b0;
         wb_dat_o               <= 32'h0000_0000;
      end else begin
         quarter_phase          <= next_phase;
         op                     <= next_op;
         last_op                <= next_last_op;
         operand                <= next_operand;
         idle_cycle             <= next_idle_cycle;
         sp                     <= next_sp;
         pc_value               <= next_pc_value;
         pc_load                <= next_pc_load;
         core_ctx               <= next_core_ctx;
         shadow                 <= next_shadow;
         pc_high_latch          <= next_lath;
         pc_upper_latch         <= next_latu;
         global_irq_enable_high <= next_gieh;
         global_irq_enable_low  <= next_giel;
         leave_high             <= next_leave_high;
         underflow              <= next_underflow;
         overflow               <= next_overflow;
         soft_reset             <= next_soft_reset;
         wb_ack_o               <= next_ack;
         wb_dat_o               <= next_dat;
      end
   end

endmodule

// >>> common/rrunit_cfg.svh
// Offsets, field positions, reset values and opcodes of the return unit.
`ifndef RRUNIT_CFG_SVH
`define RRUNIT_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses on the bus)
// ****************************************************************
`define RR_OFF_CTRL    8'h00
`define RR_OFF_WORK    8'h04
`define RR_OFF_FLAGS   8'h08
`define RR_OFF_BANK    8'h0C
`define RR_OFF_SHADOW  8'h10
`define RR_OFF_LATCH   8'h14
`define RR_OFF_PC      8'h18
`define RR_OFF_SP      8'h1C
`define RR_OFF_TOS     8'h20
`define RR_OFF_LASTOP  8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define RR_CTRL_GIEH      0
`define RR_CTRL_GIEL      1
`define RR_CTRL_LEAVE_HI  2
`define RR_CTRL_UNDER     3
`define RR_CTRL_OVER      4
`define RR_SHD_FLAGS_LSB  8
`define RR_SHD_BANK_LSB   16
`define RR_LAT_UPPER_LSB  8

// ****************************************************************
// Reset values
// ****************************************************************
`define RR_RST_WORK   8'h00
`define RR_RST_FLAGS  8'h00
`define RR_RST_BANK   4'h0
`define RR_RST_LATH   8'h00
`define RR_RST_LATU   5'h00

// ****************************************************************
// Opcodes
// ****************************************************************
`define RR_OP_SOFT_RESET  16'h00FF
`define RR_OP_IRET        16'h0010
`define RR_OP_RET         16'h0012
`define RR_OP_SEL_MASK    16'hFFFE
`define RR_OP_LIT_PREFIX  8'h0C

// ****************************************************************
// Timing: instruction cycles of a return instruction
// ****************************************************************
`define RR_RET_CYCLES  2

`endif

// >>> common/rrunit_pkg.sv
// Types shared by the return and reset instruction unit.
package rrunit_pkg;

   // ****************************************************************
   // Quarter phases of one instruction cycle
   // ****************************************************************
   typedef enum logic [3:0] {
      RR_Q1 = 4'b0001,
      RR_Q2 = 4'b0010,
      RR_Q3 = 4'b0100,
      RR_Q4 = 4'b1000
   } rrunit_phase_t;

   // ****************************************************************
   // Decoded operation
   // ****************************************************************
   typedef enum logic [4:0] {
      RR_OP_NONE = 5'b00001,
      RR_OP_SRST = 5'b00010,
      RR_OP_IRET = 5'b00100,
      RR_OP_RET  = 5'b01000,
      RR_OP_LIT  = 5'b10000
   } rrunit_op_t;

   // Working register, status and bank select travel together.
   typedef struct packed {
      logic [7:0] work;
      logic [7:0] flags;
      logic [3:0] bank_select;
   } rrunit_ctx_t;

endpackage

// >>> rtl/rrunit_stack_mem.sv
// Return stack storage with one write port and a registered read port.
`timescale 1ns/1ps

module rrunit_stack_mem #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 31,
   parameter int AW    = 5
) (
   input  wire logic             sys_clk,  // Core clock.
   input  wire logic             rstn,     // Async reset, active low.
   input  wire logic             wr_en,    // Write strobe.
   input  wire logic [AW-1:0]    wr_addr,  // Write address.
   input  wire logic [WIDTH-1:0] wr_data,  // Write data.
   input  wire logic [AW-1:0]    rd_addr,  // Read address.
   output logic      [WIDTH-1:0] rd_data   // Registered read data.
);

   logic [WIDTH-1:0] mem [DEPTH];

   // The array has no reset; only the stack pointer defines its contents.
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data lags the address by one clock.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// >>> sim/rrunit_assertions.sv
// Port assertions for the return and reset instruction unit.
`timescale 1ns/1ps
`include "rrunit_cfg.svh"
module rrunit_assertions
   import rrunit_pkg::*;
(
   input wire logic          sys_clk,     // Core clock.
   input wire logic          rstn,        // Async reset, active low.
   input wire logic          wb_cyc_i,    // Bus cycle.
   input wire logic          wb_stb_i,    // Bus strobe.
   input wire logic          wb_ack_o,    // Bus acknowledge.
   input wire logic [15:0]   instr_word,  // Opcode.
   input wire logic          instr_valid, // Opcode offered.
   input wire logic          instr_ready, // Opcode slot open.
   input wire logic [20:0]   pc_value,    // Program counter.
   input wire logic          pc_load,     // PC reload pulse.
   input wire rrunit_ctx_t   core_ctx,    // Live registers.
   input wire logic [7:0]    pc_high_latch,          // High latch.
   input wire logic          global_irq_enable_high, // High enable.
   input wire logic          global_irq_enable_low,  // Low enable.
   input wire logic          soft_reset,    // Reset pulse.
   input wire rrunit_phase_t quarter_phase  // Quarter.
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic take, is_pop, is_lit, is_ret0, is_iret, is_srst;

   // Decode the opcode taken at this Q1 edge.
   always_comb begin
      take = quarter_phase == RR_Q1 && instr_ready && instr_valid;
      is_lit = take && instr_word[15:8] == `RR_OP_LIT_PREFIX;
      is_ret0 = take && instr_word == `RR_OP_RET;
      is_iret = take && (instr_word & `RR_OP_SEL_MASK) == `RR_OP_IRET;
      is_srst = take && instr_word == `RR_OP_SOFT_RESET;
      is_pop = is_lit || is_iret
         || take && (instr_word & `RR_OP_SEL_MASK) == `RR_OP_RET;
   end

   // The pop lands only at the end of Q4, then a whole idle cycle.
   sequence s_pop_lands;
      !pc_load [*3] ##1 pc_load;
   endsequence
   sequence s_idle_cycle;
      !instr_ready [*4] ##1 instr_ready;
   endsequence

   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one clock");
   a_phase_order: assert property (quarter_phase == RR_Q2
      |=> quarter_phase == RR_Q3) else $error("phase out of order");
   a_pop_timing: assert property (is_pop |=> s_pop_lands)
      else $error("pop not in fourth quarter");
   a_idle_cycle: assert property (is_pop |-> ##4 s_idle_cycle)
      else $error("second cycle not idle");
   a_lit_work: assert property (is_lit |-> ##4
      {8'h0C, core_ctx.work} == $past(instr_word, 4))
      else $error("literal not in work");
   a_latch_kept: assert property (is_pop |-> ##4
      pc_high_latch == $past(pc_high_latch, 4)) else $error("latch moved");
   a_ret_ctx_kept: assert property (is_ret0 |-> ##4
      core_ctx == $past(core_ctx, 4)) else $error("return changed regs");
   a_iret_enable: assert property (is_iret |-> ##4 pc_load &&
      (global_irq_enable_high || global_irq_enable_low))
      else $error("enable not set at pop");
   a_srst_prompt: assert property (is_srst |-> ##[1:4] soft_reset)
      else $error("software reset late");
   a_srst_clears: assert property (soft_reset |-> core_ctx == '0
      && pc_value == '0 && !global_irq_enable_high
      && !global_irq_enable_low) else $error("reset left state");
endmodule

// >>> sim/rrunit_fetch_model.sv
// Fetch and call model that offers opcodes and pushes return addresses.
`timescale 1ns/1ps
module rrunit_fetch_model
   import rrunit_pkg::*;
(
   input  wire logic          sys_clk,       // Core clock.
   input  wire logic          instr_ready,   // Opcode slot open.
   input  wire rrunit_phase_t quarter_phase, // Current quarter.
   input  wire logic          push_ready,    // Push may be taken.
   output logic      [15:0]   instr_word,    // Offered opcode.
   output logic               instr_valid,   // Opcode offered.
   output logic               push_valid,    // Push request.
   output logic      [20:0]   push_addr      // Return address.
);
   // Idle values at time zero.
   initial begin
      instr_word = 16'hFFFF;
      instr_valid = 1'b0;
      push_valid = 1'b0;
      push_addr = 21'h1FFFFF;
   end

   // Hold the opcode until a Q1 edge takes it; a stale word would hide
   // a decoder that looks at the bus outside the slot.
   task automatic issue(input logic [15:0] op);
      @(posedge sys_clk);
      instr_word <= op;
      instr_valid <= 1'b1;
      do @(posedge sys_clk);
      while (!(quarter_phase === RR_Q1 && instr_ready === 1'b1));
      instr_valid <= 1'b0;
      instr_word <= ~op;
   endtask

   task automatic push(input logic [20:0] a);
      @(posedge sys_clk);
      push_addr <= a;
      push_valid <= 1'b1;
      do @(posedge sys_clk);
      while (push_ready !== 1'b1);
      push_valid <= 1'b0;
      push_addr <= ~a;
   endtask
endmodule

// >>> sim/rrunit_bench.sv
// Self-checking bench for the return and reset instruction unit.
`timescale 1ns/1ps
module rrunit_bench
   import rrunit_pkg::*;
;
   typedef struct packed {
      logic [15:0] op;
      logic [20:0] ret;
      rrunit_ctx_t ctx;
   } rrunit_row_t;
   logic sys_clk, rstn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [7:0] wb_adr_i, pc_high_latch;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] instr_word;
   logic instr_valid, instr_ready, push_valid, push_ready, pc_load;
   logic [20:0] push_addr, pc_value;
   logic [4:0] pc_upper_latch;
   logic gie_h, gie_l, soft_reset;
   rrunit_ctx_t core_ctx;
   rrunit_phase_t quarter_phase;
   int bad_count, num_checks, cycles;
   logic [31:0] q;
   rrunit_row_t rows [6] = '{
      '{16'h0012, 21'h0ABCD, '{8'h11, 8'h22, 4'h3}},
      '{16'h0010, 21'h1F0F0, '{8'h11, 8'h22, 4'h3}},
      '{16'h0C5A, 21'h00002, '{8'h5A, 8'h22, 4'h3}},
      '{16'h0013, 21'h10001, '{8'h3E, 8'h5C, 4'hA}},
      '{16'h0CA5, 21'h0FFFF, '{8'hA5, 8'h5C, 4'hA}},
      '{16'h0011, 21'h1FFFF, '{8'h3E, 8'h5C, 4'hA}}};

   rrunit_top DUT (.sys_clk(sys_clk), .rstn(rstn), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .instr_word(instr_word),
      .instr_valid(instr_valid), .instr_ready(instr_ready),
      .push_valid(push_valid), .push_addr(push_addr),
      .push_ready(push_ready), .pc_value(pc_value), .pc_load(pc_load),
      .core_ctx(core_ctx), .pc_high_latch(pc_high_latch),
      .pc_upper_latch(pc_upper_latch), .global_irq_enable_high(gie_h),
      .global_irq_enable_low(gie_l), .soft_reset(soft_reset),
      .quarter_phase(quarter_phase));
   rrunit_fetch_model fm (.sys_clk(sys_clk), .instr_ready(instr_ready),
      .quarter_phase(quarter_phase), .push_ready(push_ready),
      .instr_word(instr_word), .instr_valid(instr_valid),
      .push_valid(push_valid), .push_addr(push_addr));

   // Classic single Wishbone cycle; no fixed latency is assumed.
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
      @(posedge sys_clk);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge sys_clk);
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      chk(q, e);
   endtask
   // Bounded wait for a reload pulse, or the reset pulse when s is set.
   task automatic wait_hi(input logic s);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((s ? soft_reset : pc_load) !== 1'b1 && n < 40);
      chk({31'h0, n < 40}, 32'h1);
   endtask
   task automatic complete_run;
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Clock, and a cycle ceiling well above the planned run.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   // Main sequence: table of returns, then hand-written cases.
   initial begin
      {rstn, wb_we_i, wb_cyc_i, wb_stb_i} = 4'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      wb(8'h04, 1'b1, 32'h11);
      wb(8'h08, 1'b1, 32'h22);
      wb(8'h0C, 1'b1, 32'h3);
      wb(8'h10, 1'b1, 32'h000A5C3E);
      wb(8'h14, 1'b1, 32'h0000156B);
      foreach (rows[i]) begin
         fm.push(rows[i].ret);
         fm.issue(rows[i].op);
         wait_hi(1'b0);
         chk(32'(pc_value), 32'(rows[i].ret));
         chk(32'(core_ctx), 32'(rows[i].ctx));
      end
      rdchk(8'h14, 32'h0000156B);
      chk({pc_upper_latch, pc_high_latch}, 32'h156B);
      wb_sel_i <= 4'h2;
      wb(8'h14, 1'b1, 32'h0);
      wb_sel_i <= 4'hF;
      rdchk(8'h14, 32'h006B);
      rdchk(8'h00, 32'h2);
      chk({gie_h, gie_l}, 32'h1);
      fm.push(21'h00AAA);
      fm.push(21'h15555);
      fm.issue(16'h0012);
      wait_hi(1'b0);
      chk(32'(pc_value), 32'h15555);
      fm.issue(16'h0012);
      wait_hi(1'b0);
      chk(32'(pc_value), 32'h00AAA);
      rdchk(8'h1C, 32'h0);
      wb(8'h00, 1'b1, 32'h4);
      fm.push(21'h00777);
      fm.issue(16'h0010);
      wait_hi(1'b0);
      rdchk(8'h00, 32'h5);
      fm.issue(16'h00FF);
      wait_hi(1'b1);
      chk(32'(pc_value), 32'h0);
      rdchk(8'h04, 32'h0);
      rdchk(8'h14, 32'h0);
      rdchk(8'h00, 32'h0);
      wb(8'h40, 1'b1, 32'hFFFFFFFF);
      rdchk(8'h40, 32'h0);
      wb(8'h04, 1'b1, 32'h77);
      @(posedge sys_clk);
      rstn <= 1'b0;
      @(posedge sys_clk);
      chk({28'h0, quarter_phase}, 32'h1);
      chk(32'(core_ctx), 32'h0);
      rstn <= 1'b1;
      complete_run();
   end
endmodule

bind rrunit_top rrunit_assertions u_chk (.sys_clk(sys_clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .instr_word(instr_word), .instr_valid(instr_valid),
   .instr_ready(instr_ready), .pc_value(pc_value), .pc_load(pc_load),
   .core_ctx(core_ctx), .pc_high_latch(pc_high_latch),
   .global_irq_enable_high(global_irq_enable_high),
   .global_irq_enable_low(global_irq_enable_low),
   .soft_reset(soft_reset), .quarter_phase(quarter_phase));
